// file: verilog/ute_engine.sv
// Transaction handshake engine for one USB endpoint with optional ping-pong banks.
// Assumes a packet decoder and firmware port on mclk; endpoint already selected.
`timescale 1ns/10ps
module ute_engine
	import ute_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic endpointEnableBit,
	input wire logic [1:0] endpointTransferKind,
	input wire logic endpointWayBit,
	input wire logic pingPongMode,
	input wire logic controlDirBit,
	input wire logic tokValid,
	input wire logic [1:0] tokKind,
	input wire logic rxByteValid,
	input wire logic [DATA_W-1:0] rxByte,
	input wire logic rxEnd,
	input wire logic rxCrcOk,
	input wire logic rxDataOne,
	output logic txValid,
	input wire logic txReady,
	output logic [DATA_W-1:0] txData,
	output logic txEnd,
	output logic txDataOne,
	input wire logic hostAck,
	input wire logic hostTimeout,
	output logic hsValid,
	output logic [1:0] hsCode,
	input wire logic fwRdStrobe,
	output logic [DATA_W-1:0] fwRdData,
	input wire logic fwWrStrobe,
	input wire logic [DATA_W-1:0] fwWrData,
	output logic fwWrReady,
	input wire logic fwClrBank0,
	input wire logic fwClrBank1,
	input wire logic fwClrSetup,
	input wire logic fwSetTxReady,
	input wire logic fwClrTxReady,
	input wire logic fwClrTxComplete,
	input wire logic [NFLAG-1:0] irqEnable,
	output logic outBank0ReceivedFlag,
	output logic outBank1ReceivedFlag,
	output logic setupReceivedFlag,
	output logic transmitReadyFlag,
	output logic transmitCompleteFlag,
	output logic [CNT_W-1:0] endpointByteCount,
	output logic fwBank,
	output logic epIrq
);
	ute_state_e state_q;
	logic [NFLAG-1:0] flagSet, flagClr, flagQ;
	logic ctrlEp, tokIn, tokSetup, answerTok;
	logic outFree, outTarget, sendRdy, fillRdy;
	logic rxBank_q, fwBank_q, fillBank_q, sendBank_q;
	logic target_q, accept_q, isSetup_q;
	logic toggle_q, dirPrev_q;
	logic [CNT_W-1:0] rxCount_q;
	logic [CNT_W-1:0] cnt_q [2];
	logic [1:0] hsCode_q;
	logic hsValid_q, irq_q;
	logic rxDone, toggleOk, store, rxBad;
	logic txBusy, cancelReq, ackEv, fwRelease;
	logic [1:0] wrValid, wrReady, rdValid, rdReady;
	logic [1:0] flush, rewind, holdMark;
	logic [DATA_W-1:0] wrData;
	logic [DATA_W-1:0] rdData [2];

	// Token classification.
	assign ctrlEp = (endpointTransferKind == KIND_CTRL);
	assign tokIn = (tokKind == TOK_IN);
	assign tokSetup = (tokKind == TOK_SETUP);

	// Only enabled endpoints answer; non-control ones only in their way.
	assign answerTok = tokValid && (state_q == ST_IDLE) && endpointEnableBit
		&& (ctrlEp || (!tokSetup && (tokIn == (endpointWayBit == WAY_IN))));

	// Ready state of the bank to send and of the bank firmware fills.
	assign sendRdy = sendBank_q ? flagQ[FL_RDY1] : flagQ[FL_RDY0];
	assign fillRdy = fillBank_q ? flagQ[FL_RDY1] : flagQ[FL_RDY0];

	// Choice of the bank that takes an OUT or SETUP packet.
	always_comb
	begin
		outFree = 1'h0;
		outTarget = 1'h0;
		if (tokSetup)
			outFree = 1'h1;
		else if (!pingPongMode)
			outFree = !(flagQ[FL_B0] || flagQ[FL_SETUP]);
		else if (!flagQ[rxBank_q])
		begin
			outFree = 1'h1;
			outTarget = rxBank_q;
		end
		else if (!flagQ[!rxBank_q])
		begin
			outFree = 1'h1;
			outTarget = !rxBank_q;
		end
	end

	// End-of-packet qualification.
	assign rxDone = (state_q == ST_RX) && rxEnd;
	assign toggleOk = isSetup_q || (rxDataOne == toggle_q);
	assign store = rxDone && rxCrcOk && accept_q && toggleOk;
	assign rxBad = rxDone && accept_q && !(rxCrcOk && toggleOk);

	// IN side events.
	assign txBusy = (state_q == ST_SEND) || (state_q == ST_WAIT);
	assign cancelReq = fwClrTxReady && !txBusy;
	assign ackEv = (state_q == ST_WAIT) && hostAck;
	assign fwRelease = (fwClrBank0 && !fwBank_q) || (fwClrBank1 && fwBank_q);

	// Transaction sequencing.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else if (ce)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (answerTok && tokIn)
						state_q <= sendRdy ? ST_SEND : ST_IDLE;
					else if (answerTok)
						state_q <= ST_RX;
				end
				ST_RX:
				begin
					if (rxEnd)
						state_q <= ST_IDLE;
				end
				ST_SEND:
				begin
					if (!rdValid[sendBank_q])
						state_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (hostAck || hostTimeout)
						state_q <= ST_IDLE;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Decision taken at the OUT or SETUP token.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			isSetup_q <= 1'h0;
			accept_q <= 1'h0;
			target_q <= BANK_RST;
		end
		else if (ce && answerTok && !tokIn)
		begin
			isSetup_q <= tokSetup;
			accept_q <= outFree;
			target_q <= outTarget;
		end
	end

	// Every byte the host sends is counted, stored or not.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rxCount_q <= CNT_RST;
		else if (ce)
		begin
			if (answerTok)
				rxCount_q <= CNT_RST;
			else if ((state_q == ST_RX) && rxByteValid)
				rxCount_q <= rxCount_q + CNT_W'(1);
		end
	end

	// Byte counts per bank, loaded only by a stored packet.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q[0] <= CNT_RST;
			cnt_q[1] <= CNT_RST;
		end
		else if (ce && store)
			cnt_q[target_q] <= rxCount_q;
	end

	// Handshake answer, one cycle after the token or packet end.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			hsValid_q <= 1'h0;
			hsCode_q <= HS_NONE;
		end
		else if (ce)
		begin
			hsValid_q <= 1'h0;
			hsCode_q <= HS_NONE;
			if (answerTok && tokIn && !sendRdy)
			begin
				hsValid_q <= 1'h1;
				hsCode_q <= HS_NAK;
			end
			else if (rxDone && rxCrcOk)
			begin
				hsValid_q <= 1'h1;
				hsCode_q <= accept_q ? HS_ACK : HS_NAK;
			end
		end
	end

	// Hardware and firmware events on the status flags.
	always_comb
	begin
		flagSet = '0;
		flagClr = '0;
		if (store && !isSetup_q)
			flagSet[target_q] = 1'h1;
		if (store && isSetup_q)
		begin
			flagSet[FL_SETUP] = 1'h1;
			flagClr[FL_B0] = 1'h1;
			flagClr[FL_B1] = 1'h1;
			flagClr[FL_RDY0] = 1'h1;
			flagClr[FL_RDY1] = 1'h1;
			flagClr[FL_CMPL] = 1'h1;
		end
		if (fwClrBank0)
			flagClr[FL_B0] = 1'h1;
		if (fwClrBank1)
			flagClr[FL_B1] = 1'h1;
		if (fwClrSetup)
			flagClr[FL_SETUP] = 1'h1;
		if (fwSetTxReady)
			flagSet[fillBank_q ? FL_RDY1 : FL_RDY0] = 1'h1;
		if (cancelReq)
			flagClr[sendBank_q ? FL_RDY1 : FL_RDY0] = 1'h1;
		if (ackEv)
		begin
			flagClr[sendBank_q ? FL_RDY1 : FL_RDY0] = 1'h1;
			flagSet[FL_CMPL] = 1'h1;
		end
		if (fwClrTxComplete)
			flagClr[FL_CMPL] = 1'h1;
	end

	// One sticky flag per status bit.
	ute_flag uFlag [NFLAG-1:0]
	(
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.setEv(flagSet),
		.clrEv(flagClr),
		.flagQ(flagQ)
	);

	// Next OUT bank alternates after each stored OUT packet.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rxBank_q <= BANK_RST;
		else if (ce && store && !isSetup_q && pingPongMode)
			rxBank_q <= !target_q;
	end

	// Firmware read bank swaps when it releases the bank it reads.
	// Standard mode always reads bank 0, so a bank left over from ping-pong returns there.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			fwBank_q <= BANK_RST;
		else if (ce && (pingPongMode ? fwRelease : fwBank_q))
			fwBank_q <= !fwBank_q;
	end

	// Firmware fill bank switches at each transmit-ready set.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			fillBank_q <= BANK_RST;
		else if (ce && pingPongMode)
		begin
			if (cancelReq)
				fillBank_q <= sendBank_q;
			else if (fwSetTxReady)
				fillBank_q <= !fillBank_q;
		end
	end

	// Send bank advances only after the host acknowledges.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sendBank_q <= BANK_RST;
		else if (ce && pingPongMode && ackEv)
			sendBank_q <= !sendBank_q;
	end

	// Data toggle: setup starts DATA1 next, a direction change restarts at DATA1.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			toggle_q <= TOGGLE_RST;
			dirPrev_q <= 1'h0;
		end
		else if (ce)
		begin
			dirPrev_q <= controlDirBit;
			if (store)
				toggle_q <= isSetup_q ? 1'h1 : !toggle_q;
			else if (ackEv)
				toggle_q <= !toggle_q;
			else if (ctrlEp && (controlDirBit != dirPrev_q))
				toggle_q <= 1'h1;
		end
	end

	// Bank storage: host or firmware writes, sender or firmware reads.
	assign wrData = (state_q == ST_RX) ? rxByte : fwWrData;
	for (genvar b = 0; b < 2; b++)
	begin : gBank
		// Excess host bytes fall away when the bank is full.
		assign wrValid[b] = (state_q == ST_RX)
			? (accept_q && rxByteValid && (target_q == b))
			: (fwWrStrobe && (fillBank_q == b));
		assign rdReady[b] = (state_q == ST_SEND)
			? (txReady && (sendBank_q == b))
			: (fwRdStrobe && (fwBank_q == b));
		// Emptied at acceptance, on a bad packet, on cancel, or on control release.
		assign flush[b] = (answerTok && !tokIn && outFree && (outTarget == b))
			|| (rxBad && (target_q == b))
			|| (cancelReq && (sendBank_q == b))
			|| (ctrlEp && fwClrBank0 && (b == 0));
		assign rewind[b] = (state_q == ST_WAIT) && hostTimeout && (sendBank_q == b);
		assign holdMark[b] = txBusy && (sendBank_q == b);
		ute_fifo #(
			.W(DATA_W),
			.D(FIFO_DEPTH)
		) uFifo (
			.mclk(mclk),
			.rst(rst),
			.ce(ce),
			.flush(flush[b]),
			.rewind(rewind[b]),
			.holdMark(holdMark[b]),
			.wrValid(wrValid[b]),
			.wrData(wrData),
			.wrReady(wrReady[b]),
			.rdValid(rdValid[b]),
			.rdData(rdData[b]),
			.rdReady(rdReady[b])
		);
	end

	// Interrupt request from enabled event flags.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			irq_q <= 1'h0;
		else if (ce)
			irq_q <= |(flagQ & irqEnable & IRQ_SRC_MASK);
	end

	// Transmit stream; an empty bank ends at once as a zero-length packet.
	assign txValid = (state_q == ST_SEND) && rdValid[sendBank_q];
	assign txData = rdData[sendBank_q];
	assign txEnd = (state_q == ST_SEND) && !rdValid[sendBank_q];
	assign txDataOne = toggle_q;

	// Firmware view.
	assign fwRdData = rdData[fwBank_q];
	assign fwWrReady = (state_q != ST_RX) && wrReady[fillBank_q];
	assign fwBank = fwBank_q;
	assign endpointByteCount = cnt_q[fwBank_q];
	assign outBank0ReceivedFlag = flagQ[FL_B0];
	assign outBank1ReceivedFlag = flagQ[FL_B1];
	assign setupReceivedFlag = flagQ[FL_SETUP];
	assign transmitReadyFlag = fillRdy;
	assign transmitCompleteFlag = flagQ[FL_CMPL];
	assign hsValid = hsValid_q;
	assign hsCode = hsCode_q;
	assign epIrq = irq_q;
endmodule : ute_engine

// file: verilog/ute_pkg.sv
// Constants, encodings and state codes of the endpoint transaction engine.
// Assumes one clock domain and a token decoder on the same clock.
package ute_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W = 8;
	localparam logic [1:0] KIND_CTRL = 2'h0;
	localparam logic [1:0] KIND_ISO = 2'h1;
	localparam logic [1:0] KIND_BULK = 2'h2;
	localparam logic [1:0] KIND_INTR = 2'h3;
	localparam logic WAY_IN = 1'h1;
	localparam logic WAY_OUT = 1'h0;
	// Flag indices; the two received flags must sit at 0 and 1.
	localparam int NFLAG = 6;
	localparam int FL_B0 = 0;
	localparam int FL_B1 = 1;
	localparam int FL_SETUP = 2;
	localparam int FL_RDY0 = 3;
	localparam int FL_RDY1 = 4;
	localparam int FL_CMPL = 5;
	localparam logic [NFLAG-1:0] IRQ_SRC_MASK = 6'h27;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic FLAG_RST = 1'h0;
	localparam logic BANK_RST = 1'h0;
	localparam logic TOGGLE_RST = 1'h0;
	typedef enum logic [1:0] {TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h2} ute_tok_e;
	typedef enum logic [1:0] {HS_NONE = 2'h0, HS_ACK = 2'h1, HS_NAK = 2'h2} ute_hs_e;
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_RX = 4'h2,
		ST_SEND = 4'h4,
		ST_WAIT = 4'h8
	} ute_state_e;
endpackage : ute_pkg

// file: verilog/ute_flag.sv
// Sticky status flag set and cleared by firmware or hardware events.
// Assumes set and clear are single-cycle pulses on mclk.
`timescale 1ns/10ps
module ute_flag
	import ute_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic setEv,
	input wire logic clrEv,
	output logic flagQ
);
	// A set arriving with a clear wins, so no event is lost.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			flagQ <= FLAG_RST;
		else if (ce)
		begin
			if (setEv)
				flagQ <= 1'h1;
			else if (clrEv)
				flagQ <= 1'h0;
		end
	end
endmodule : ute_flag

// file: verilog/ute_fifo.sv
// Flip-flop FIFO bank with flush and a read mark that allows a replay.
// Assumes all controls are synchronous to mclk.
`timescale 1ns/10ps
module ute_fifo
	import ute_pkg::*;
#(
	parameter int W = DATA_W,
	parameter int D = FIFO_DEPTH
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic flush,
	input wire logic rewind,
	input wire logic holdMark,
	input wire logic wrValid,
	input wire logic [W-1:0] wrData,
	output logic wrReady,
	output logic rdValid,
	output logic [W-1:0] rdData,
	input wire logic rdReady
);
	localparam int AW = $clog2(D);
	logic [AW:0] wrPtr_q, rdPtr_q, markPtr_q, rdNext;
	logic [W-1:0] mem_q [D];
	logic push, pop;

	// Full is judged against the mark, so replayable data is never overwritten.
	assign wrReady = !((wrPtr_q[AW] != markPtr_q[AW]) && (wrPtr_q[AW-1:0] == markPtr_q[AW-1:0]));
	assign rdValid = (rdPtr_q != wrPtr_q);
	assign rdData = mem_q[rdPtr_q[AW-1:0]];
	assign push = wrValid && wrReady;
	assign pop = rdValid && rdReady;
	assign rdNext = pop ? rdPtr_q + (AW+1)'(1) : rdPtr_q;

	// Pointers: flush empties, rewind replays from the mark.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			markPtr_q <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wrPtr_q <= '0;
				rdPtr_q <= '0;
				markPtr_q <= '0;
			end
			else
			begin
				if (push)
					wrPtr_q <= wrPtr_q + (AW+1)'(1);
				rdPtr_q <= rewind ? markPtr_q : rdNext;
				if (!holdMark)
					markPtr_q <= rdNext;
			end
		end
	end

	// Storage.
	always_ff @(posedge mclk)
	begin
		if (ce && push && !flush)
			mem_q[wrPtr_q[AW-1:0]] <= wrData;
	end
endmodule : ute_fifo

// file: sim/ute_engine_monitor.sv
// Concurrent checks on the handshake, flag and count ports of the endpoint engine.
// Assumes ce is held high and that all ports belong to the mclk domain.
`timescale 1ns/10ps
module ute_engine_monitor
	import ute_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic endpointEnableBit,
	input wire logic [1:0] endpointTransferKind,
	input wire logic endpointWayBit,
	input wire logic pingPongMode,
	input wire logic tokValid,
	input wire logic [1:0] tokKind,
	input wire logic txValid,
	input wire logic hostAck,
	input wire logic hsValid,
	input wire logic [1:0] hsCode,
	input wire logic fwRdStrobe,
	input wire logic [NFLAG-1:0] irqEnable,
	input wire logic outBank0ReceivedFlag,
	input wire logic setupReceivedFlag,
	input wire logic transmitReadyFlag,
	input wire logic transmitCompleteFlag,
	input wire logic [CNT_W-1:0] endpointByteCount,
	input wire logic epIrq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// A received flag only rises together with an ACK.
	property p_outAck;
		$rose(outBank0ReceivedFlag) |-> hsValid && hsCode == HS_ACK;
	endproperty
	a_outAck: assert property (p_outAck) else $error("bank0 flag rose without ACK");
	// An enabled source raises the interrupt one cycle later.
	property p_irq;
		$rose(outBank0ReceivedFlag) && irqEnable[FL_B0] |=> epIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing after receive");
	// A full single bank must not be acknowledged again.
	property p_nakFull;
		hsValid && hsCode == HS_ACK && !pingPongMode && endpointTransferKind != KIND_CTRL
			|-> !$past(outBank0ReceivedFlag);
	endproperty
	a_nakFull: assert property (p_nakFull) else $error("ACK while bank0 was full");
	// Completion follows a host acknowledge by one cycle.
	property p_cmpl;
		$rose(transmitCompleteFlag) |-> $past(hostAck);
	endproperty
	a_cmpl: assert property (p_cmpl) else $error("completion without host ACK");
	// A disabled endpoint stays silent.
	property p_dis;
		(!endpointEnableBit)[*4] |-> !hsValid && !txValid;
	endproperty
	a_dis: assert property (p_dis) else $error("disabled endpoint answered");
	// An IN token without ready data is refused with NAK.
	property p_inNak;
		tokValid && tokKind == TOK_IN && endpointEnableBit && endpointWayBit == WAY_IN
			&& !pingPongMode && endpointTransferKind != KIND_CTRL && !transmitReadyFlag
			|=> hsValid && hsCode == HS_NAK;
	endproperty
	a_inNak: assert property (p_inNak) else $error("IN without ready not refused");
	// Reading the FIFO leaves the byte count alone.
	property p_cntHold;
		fwRdStrobe && !pingPongMode |=> $stable(endpointByteCount);
	endproperty
	a_cntHold: assert property (p_cntHold) else $error("count moved on FIFO read");
	// A setup packet clears the other status bits and is acknowledged.
	property p_setup;
		$rose(setupReceivedFlag) |-> !outBank0ReceivedFlag && !transmitReadyFlag
			&& !transmitCompleteFlag && hsValid && hsCode == HS_ACK;
	endproperty
	a_setup: assert property (p_setup) else $error("setup did not clear status");
endmodule : ute_engine_monitor

bind ute_engine ute_engine_monitor u_mon (.mclk(mclk), .rst(rst),
	.endpointEnableBit(endpointEnableBit), .endpointTransferKind(endpointTransferKind),
	.endpointWayBit(endpointWayBit), .pingPongMode(pingPongMode), .tokValid(tokValid),
	.tokKind(tokKind), .txValid(txValid), .hostAck(hostAck), .hsValid(hsValid),
	.hsCode(hsCode), .fwRdStrobe(fwRdStrobe), .irqEnable(irqEnable),
	.outBank0ReceivedFlag(outBank0ReceivedFlag), .setupReceivedFlag(setupReceivedFlag),
	.transmitReadyFlag(transmitReadyFlag), .transmitCompleteFlag(transmitCompleteFlag),
	.endpointByteCount(endpointByteCount), .epIrq(epIrq));

// file: sim/ute_host_model.sv
// Behavioural host that issues tokens and data packets and takes IN data.
// Assumes the engine's token, byte and handshake timing on mclk.
`timescale 1ns/10ps
module ute_host_model
	import ute_pkg::*;
(
	input wire logic mclk,
	output logic tokValid,
	output logic [1:0] tokKind,
	output logic rxByteValid,
	output logic [DATA_W-1:0] rxByte,
	output logic rxEnd,
	output logic rxCrcOk,
	output logic rxDataOne,
	input wire logic txValid,
	input wire logic [DATA_W-1:0] txData,
	input wire logic txEnd,
	input wire logic txDataOne,
	output logic txReady,
	output logic hostAck,
	output logic hostTimeout,
	input wire logic hsValid,
	input wire logic [1:0] hsCode
);
	logic tgl = 1'h0;
	logic slow = 1'h0;
	logic inOne = 1'h0;
	logic [DATA_W-1:0] inBuf [$];
	// Idle levels at time zero.
	initial
	begin
		{tokValid, tokKind, rxByteValid, rxByte, rxEnd, rxCrcOk, rxDataOne} = '0;
		{txReady, hostAck, hostTimeout} = 3'h4;
	end
	// One token pulse.
	task token(input logic [1:0] k);
		@(posedge mclk);
		tokValid <= 1'h1;
		tokKind <= k;
		@(posedge mclk);
		tokValid <= 1'h0;
	endtask : token
	// Token, n bytes counting up from base, end of packet, then the handshake.
	task out_pkt(input logic [1:0] k, input int n, input logic [7:0] base, input logic crc,
		output logic [1:0] hs);
		hs = HS_NONE;
		token(k);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			rxByteValid <= 1'h1;
			rxByte <= 8'(base + i);
		end
		@(posedge mclk);
		rxByteValid <= 1'h0;
		rxByte <= ~rxByte;
		rxEnd <= 1'h1;
		rxCrcOk <= crc;
		rxDataOne <= (k == TOK_SETUP) ? 1'h0 : tgl;
		@(posedge mclk);
		rxEnd <= 1'h0;
		rxCrcOk <= ~crc;
		rxDataOne <= ~rxDataOne;
		for (int i = 0; i < 4; i++)
		begin
			#1;
			if (hsValid === 1'h1)
				hs = hsCode;
			@(posedge mclk);
		end
		if (hs == HS_ACK)
			tgl = (k == TOK_SETUP) ? 1'h1 : ~tgl;
		#1;
	endtask : out_pkt
	// IN token, collect bytes until end of packet, then acknowledge or time out.
	task in_pkt(input logic ack, output logic [1:0] hs);
		logic done;
		done = 1'h0;
		hs = HS_NONE;
		inBuf.delete();
		token(TOK_IN);
		for (int i = 0; i < 80 && !done && hs == HS_NONE; i++)
		begin
			#1;
			if (hsValid === 1'h1)
				hs = hsCode;
			if (txValid === 1'h1 && txReady === 1'h1)
				inBuf.push_back(txData);
			if (txEnd === 1'h1)
				done = 1'h1;
			inOne = txDataOne;
			@(posedge mclk);
			txReady <= slow ? ~txReady : 1'h1;
		end
		if (done)
		begin
			hostAck <= ack;
			hostTimeout <= !ack;
			@(posedge mclk);
			{hostAck, hostTimeout} <= 2'h0;
			// One more cycle lets the completion interrupt settle.
			@(posedge mclk);
		end
		else if (hs == HS_NONE)
			hs = 2'h3;
		#1;
	endtask : in_pkt
endmodule : ute_host_model

// file: sim/tb_top.sv
// Self-checking bench for the endpoint engine, driven through host and firmware tasks.
// Assumes the host model in its own file and the checker bound to the engine.
`timescale 1ns/10ps
module tb_top;
	import ute_pkg::*;
	localparam logic [7:0] CB0 = 8'h01, CB1 = 8'h02, CSU = 8'h04, SET = 8'h08;
	localparam logic [7:0] CTR = 8'h10, CTC = 8'h20, RD = 8'h40, WR = 8'h80;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic en = 1'h0, way = 1'h0, pp = 1'h0, dir = 1'h0;
	logic [1:0] kind = 2'h2;
	logic [5:0] irq = 6'h27;
	logic [7:0] fwOp = 8'h00, wrData = 8'h00;
	logic [1:0] hs, tokKind, hsCode;
	logic tokValid, rxByteValid, rxEnd, rxCrcOk, rxDataOne, txReady, hostAck, hostTimeout;
	logic txValid, txEnd, txDataOne, hsValid, fwWrReady, fwBank, epIrq;
	logic b0, b1, setupFlag, rdyFlag, cmplFlag;
	logic [7:0] rxByte, txData, fwRdData, count;
	int bad_count = 0, tests_run = 0;
	// Free-running 40 MHz clock.
	always #12.5 mclk = ~mclk;
	ute_engine dut (.mclk(mclk), .rst(rst), .ce(1'h1), .endpointEnableBit(en),
		.endpointTransferKind(kind), .endpointWayBit(way), .pingPongMode(pp),
		.controlDirBit(dir), .tokValid(tokValid), .tokKind(tokKind),
		.rxByteValid(rxByteValid), .rxByte(rxByte), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk),
		.rxDataOne(rxDataOne), .txValid(txValid), .txReady(txReady), .txData(txData),
		.txEnd(txEnd), .txDataOne(txDataOne), .hostAck(hostAck), .hostTimeout(hostTimeout),
		.hsValid(hsValid), .hsCode(hsCode), .fwRdStrobe(fwOp[6]), .fwRdData(fwRdData),
		.fwWrStrobe(fwOp[7]), .fwWrData(wrData), .fwWrReady(fwWrReady),
		.fwClrBank0(fwOp[0]), .fwClrBank1(fwOp[1]), .fwClrSetup(fwOp[2]),
		.fwSetTxReady(fwOp[3]), .fwClrTxReady(fwOp[4]), .fwClrTxComplete(fwOp[5]),
		.irqEnable(irq), .outBank0ReceivedFlag(b0), .outBank1ReceivedFlag(b1),
		.setupReceivedFlag(setupFlag), .transmitReadyFlag(rdyFlag),
		.transmitCompleteFlag(cmplFlag), .endpointByteCount(count), .fwBank(fwBank),
		.epIrq(epIrq));
	ute_host_model host (.mclk(mclk), .tokValid(tokValid), .tokKind(tokKind),
		.rxByteValid(rxByteValid), .rxByte(rxByte), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk),
		.rxDataOne(rxDataOne), .txValid(txValid), .txData(txData), .txEnd(txEnd),
		.txDataOne(txDataOne), .txReady(txReady), .hostAck(hostAck),
		.hostTimeout(hostTimeout), .hsValid(hsValid), .hsCode(hsCode));
	// Compare one value and count the outcome.
	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One firmware pulse with optional write data.
	task fw(input logic [7:0] op, input logic [7:0] d);
		@(posedge mclk);
		fwOp <= op;
		wrData <= d;
		@(posedge mclk);
		fwOp <= 8'h00;
		#1;
	endtask : fw
	// Read n bytes and compare them with an up-counting pattern.
	task read_chk(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++)
		begin
			check(fwRdData, 8'(base + i));
			fw(RD, 8'h00);
		end
	endtask : read_chk
	// Endpoint configuration levels.
	task cfg(input logic e, input logic [1:0] k, input logic w, input logic p,
		input logic [5:0] m, input logic d);
		@(posedge mclk);
		en <= e;
		kind <= k;
		way <= w;
		pp <= p;
		irq <= m;
		dir <= d;
		#1;
	endtask : cfg
	// Counts, verdict and end of run.
	task end_of_test;
		$display("Mismatches %0d of %0d checks", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		end_of_test;
	end
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		cfg(1'h1, KIND_BULK, WAY_OUT, 1'h0, 6'h27, 1'h0);
		host.out_pkt(TOK_OUT, 3, 8'h10, 1'h1, hs);
		check(hs, HS_ACK);
		check(b0, 1'h1);
		check(epIrq, 1'h1);
		check(count, 8'h03);
		host.out_pkt(TOK_OUT, 2, 8'h40, 1'h1, hs);
		check(hs, HS_NAK);
		read_chk(3, 8'h10);
		check(count, 8'h03);
		fw(CB0, 8'h00);
		host.out_pkt(TOK_OUT, 34, 8'h80, 1'h1, hs);
		check(hs, HS_ACK);
		check(count, 8'h22);
		read_chk(32, 8'h80);
		fw(CB0, 8'h00);
		cfg(1'h1, KIND_BULK, WAY_OUT, 1'h0, 6'h00, 1'h0);
		host.out_pkt(TOK_OUT, 0, 8'h00, 1'h1, hs);
		check(count, 8'h00);
		check(epIrq, 1'h0);
		fw(CB0, 8'h00);
		host.out_pkt(TOK_OUT, 4, 8'h20, 1'h0, hs);
		check(hs, HS_NONE);
		check(b0, 1'h0);
		cfg(1'h0, KIND_BULK, WAY_OUT, 1'h0, 6'h27, 1'h0);
		host.out_pkt(TOK_OUT, 1, 8'h20, 1'h1, hs);
		check(hs, HS_NONE);
		cfg(1'h1, KIND_BULK, WAY_OUT, 1'h1, 6'h27, 1'h0);
		host.out_pkt(TOK_OUT, 2, 8'h30, 1'h1, hs);
		host.out_pkt(TOK_OUT, 3, 8'h50, 1'h1, hs);
		check({b1, b0}, 2'h3);
		host.out_pkt(TOK_OUT, 1, 8'h70, 1'h1, hs);
		check(hs, HS_NAK);
		check({fwBank, count}, 9'h002);
		read_chk(2, 8'h30);
		fw(CB0, 8'h00);
		check({fwBank, count}, 9'h103);
		host.out_pkt(TOK_OUT, 1, 8'h70, 1'h1, hs);
		check({hs, b0}, {HS_ACK, 1'h1});
		read_chk(3, 8'h50);
		fw(CB1, 8'h00);
		read_chk(1, 8'h70);
		fw(CB0, 8'h00);
		cfg(1'h1, KIND_BULK, WAY_IN, 1'h0, 6'h27, 1'h0);
		host.in_pkt(1'h1, hs);
		check(hs, HS_NAK);
		fw(WR, 8'ha1);
		fw(WR, 8'ha2);
		fw(SET, 8'h00);
		host.slow = 1'h1;
		host.in_pkt(1'h0, hs);
		host.slow = 1'h0;
		check({host.inBuf.size(), host.inBuf[0], cmplFlag}, {32'd2, 8'ha1, 1'h0});
		host.in_pkt(1'h1, hs);
		check({host.inBuf.size(), host.inBuf[1]}, {32'd2, 8'ha2});
		check({cmplFlag, epIrq}, 2'h3);
		fw(CTC, 8'h00);
		fw(WR, 8'hb1);
		fw(SET, 8'h00);
		fw(CTR, 8'h00);
		check(fwWrReady, 1'h1);
		host.in_pkt(1'h1, hs);
		check(hs, HS_NAK);
		fw(SET, 8'h00);
		host.in_pkt(1'h1, hs);
		check({hs, host.inBuf.size()}, {HS_NONE, 32'd0});
		fw(CTC, 8'h00);
		cfg(1'h1, KIND_BULK, WAY_IN, 1'h1, 6'h27, 1'h0);
		fw(WR, 8'hc1);
		fw(SET, 8'h00);
		check(rdyFlag, 1'h0);
		fw(WR, 8'hc2);
		fw(SET, 8'h00);
		host.in_pkt(1'h1, hs);
		check(host.inBuf[0], 8'hc1);
		fw(CTC, 8'h00);
		host.in_pkt(1'h1, hs);
		check(host.inBuf[0], 8'hc2);
		fw(CTC, 8'h00);
		host.in_pkt(1'h1, hs);
		check(hs, HS_NAK);
		cfg(1'h1, KIND_CTRL, WAY_IN, 1'h0, 6'h27, 1'h0);
		fw(SET, 8'h00);
		host.out_pkt(TOK_SETUP, 8, 8'h60, 1'h1, hs);
		check({hs, setupFlag, rdyFlag}, {HS_ACK, 2'h2});
		read_chk(8, 8'h60);
		fw(CSU, 8'h00);
		cfg(1'h1, KIND_CTRL, WAY_IN, 1'h0, 6'h27, 1'h1);
		fw(WR, 8'hd1);
		fw(SET, 8'h00);
		host.in_pkt(1'h1, hs);
		check({host.inBuf[0], host.inOne}, {8'hd1, 1'h1});
		fw(CTC, 8'h00);
		cfg(1'h1, KIND_CTRL, WAY_IN, 1'h0, 6'h27, 1'h0);
		host.out_pkt(TOK_OUT, 0, 8'h00, 1'h1, hs);
		check({hs, b0}, {HS_ACK, 1'h1});
		fw(CB0, 8'h00);
		check(b0, 1'h0);
		end_of_test;
	end
endmodule : tb_top
